// ==== core/clkgen_pkg.sv ====
/*
  Constants, field positions, reset values and carrier types for the clock
  generator control block: second control register, period adjust register
  and the few extra control and status bits that the block needs.
  Assumes a single 100 MHz system clock and an AHB-Lite register bus.
*/
// Overview of operation
// - bus divider 7:6 divides source 1/2/4/8
// - bus divider resets to code 01
// - bit 5 selects high or low range
// - bit 4 selects high gain oscillator
// - bit 3 stops loop in bypassed modes
// - bit 2 picks crystal or direct clock
// - bit 1 enables external reference output
// - bit 0 keeps external reference in stop
// - eight bit binary weighted period adjust
// - larger adjust value gives longer period
// - fine adjust bit in status register
// - source select 00 loop 01 int 10 ext
// - adjust change in internal loop mode clears lock
package clkgen_pkg;

  // ==========================================================
  // register map (register indexes, taken from byte address bits 3:2)
  // ==========================================================
  localparam int          ADDR_W          = 12;
  localparam logic [1:0]  IDX_CTRL_ONE    = 2'h0; // clock_gen_control_one
  localparam logic [1:0]  IDX_CTRL_TWO    = 2'h1; // clock_gen_control_two
  localparam logic [1:0]  IDX_PERIOD_ADJ  = 2'h2; // internal_ref_period_adjust
  localparam logic [1:0]  IDX_STATUS_CTRL = 2'h3; // clock_gen_status_control
  localparam int          IDX_LSB         = 2;
  localparam int          IDX_MSB         = 3;
  localparam int          DEC_LSB         = 4;

  // ==========================================================
  // field positions
  // ==========================================================
  localparam int SRC_SEL_MSB   = 7; // control one: system_source_select
  localparam int SRC_SEL_LSB   = 6;
  localparam int INT_REF_SEL   = 2; // control one: loop reference internal
  localparam int BUS_CLOCK_DIVIDER_MSB      = 7; // control two: bus_clock_divider
  localparam int BUS_CLOCK_DIVIDER_LSB      = 6;
  localparam int RANGE_BIT     = 5;
  localparam int HIGH_GAIN_BIT = 4;
  localparam int LP_BYPASS_BIT = 3;
  localparam int REF_SRC_BIT   = 2;
  localparam int OUT_EN_BIT    = 1;
  localparam int KEEP_STOP_BIT = 0;
  localparam int LOCK_BIT      = 6; // status/control: lock indication
  localparam int FINE_BIT      = 0; // status/control: fine_period_adjust

  // ==========================================================
  // reset values
  // ==========================================================
  localparam logic [7:0] RST_CTRL_ONE   = 8'h04;
  localparam logic [7:0] RST_CTRL_TWO   = 8'h40;
  localparam logic [7:0] RST_PERIOD_ADJ = 8'h80;
  localparam logic       RST_FINE       = 1'b0;

  // ==========================================================
  // source select codes and bus protocol
  // ==========================================================
  localparam logic [1:0] SRC_LOOP     = 2'h0;
  localparam logic [1:0] SRC_INT_REF  = 2'h1;
  localparam logic [1:0] SRC_EXT_REF  = 2'h2;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam logic       HRESP_OKAY    = 1'b0;

  // ==========================================================
  // internal reference period model, in hclk cycles
  // ==========================================================
  localparam int         ADJ_W          = 9;   // eight coarse plus fine
  localparam int         IRC_CNT_W      = 10;
  localparam logic [9:0] IRC_BASE_CYCLES = 10'h010;

  // decoded control fields that travel together to the clock logic
  typedef struct packed {
    logic [1:0] src_sel;
    logic       int_ref_sel;
    logic [1:0] bus_div;
    logic       high_range;
    logic       high_gain;
    logic       lp_bypass;
    logic       ref_src_osc;
    logic       out_en;
    logic       keep_in_stop;
  } clkgen_ctrl_t;

  // all state of the top module
  typedef struct packed {
    logic [7:0]  ctrl_one;
    logic [7:0]  ctrl_two;
    logic [7:0]  period_adj;
    logic        fine_adj;
    logic        lock;
    logic        locked_prev;
    logic        stop_prev;
    logic        ext_before_stop;
    logic        wr_pend;
    logic [1:0]  wr_idx;
    logic [31:0] hrdata;
    logic        high_range;
    logic        high_gain;
    logic        ref_src_osc;
    logic        loop_en;
    logic        ext_ref_run;
    logic        ext_ref_out;
    logic        int_ref_run;
  } clkgen_state_t;

endpackage : clkgen_pkg

// ==== core/clkgen_bus_div.sv ====
/*
  Bus clock divider: counts ticks of the selected source and emits one
  bus tick every 1, 2, 4 or 8 source ticks.
  Assumes the source tick is a one-cycle pulse synchronous to hclk.
*/
`timescale 1ns/1ps
`default_nettype none
module clkgen_bus_div
  import clkgen_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       src_tick,   // one pulse per source period
  input  wire logic [1:0] div_code,   // 00 /1, 01 /2, 10 /4, 11 /8
  output var  logic       bus_tick    // one pulse per bus period
);

  // last count value before the bus tick for a divider code
  function automatic logic [2:0] div_last(input logic [1:0] code);
    div_last = 3'(({2'h0, 1'b1} << code) - 3'h1);
  endfunction : div_last

  typedef struct packed {
    logic [2:0] cnt;
    logic       tick;
  } clkgen_div_state_t;

  clkgen_div_state_t st;       // registered state
  clkgen_div_state_t next_st;  // next state

  // ==========================================================
  // divide selected source
  // ==========================================================
  // a code change mid-count ends the period at the next source tick once
  // the count is at or past the new last value; none is ever shortened below /1
  always_comb
  begin
    next_st      = st;
    next_st.tick = 1'b0;
    if (src_tick)
    begin
      if (st.cnt >= div_last(div_code))
      begin
        next_st.cnt  = 3'h0;
        next_st.tick = 1'b1;
      end
      else
      begin
        next_st.cnt = st.cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign bus_tick = st.tick;

endmodule : clkgen_bus_div
`default_nettype wire

// ==== core/clkgen_irc.sv ====
/*
  Internal reference period model: emits one tick per internal reference
  period, the period being a base plus the nine-bit adjust value.
  Assumes the adjust value is held in registers of the caller.
*/
`timescale 1ns/1ps
`default_nettype none
module clkgen_irc
  import clkgen_pkg::*;
(
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             run,     // reference enabled
  input  wire logic [ADJ_W-1:0] adjust,  // {coarse, fine}, binary weighted
  output var  logic             tick     // one pulse per period
);

  typedef struct packed {
    logic [IRC_CNT_W-1:0] cnt;
    logic                 tick;
  } clkgen_irc_state_t;

  clkgen_irc_state_t st;       // registered state
  clkgen_irc_state_t next_st;  // next state
  logic [IRC_CNT_W-1:0] last;  // final count of the period

  // ==========================================================
  // period counter
  // ==========================================================
  // each adjust bit weighs twice the one below; a larger value adds
  // cycles, so the period grows with the value
  always_comb
  begin
    last         = IRC_BASE_CYCLES + IRC_CNT_W'(adjust);
    next_st      = st;
    next_st.tick = 1'b0;
    if (!run)
      next_st.cnt = '0;
    else if (st.cnt >= last)
    begin
      next_st.cnt  = '0;
      next_st.tick = 1'b1;
    end
    else
      next_st.cnt = st.cnt + IRC_CNT_W'(1);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign tick = st.tick;

endmodule : clkgen_irc
`default_nettype wire

// ==== core/clkgen_ctrl.sv ====
/*
  Clock generator control: AHB-Lite slave holding both control registers,
  the period adjust register and the status/control bits, plus the logic
  that these fields steer: bus divider, internal reference, loop enable,
  oscillator settings and external reference gating in stop.
  Assumes source ticks and stop request are synchronous to hclk, and that
  the loop reports lock on loop_locked.
*/
// Our own choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module clkgen_ctrl
  import clkgen_pkg::*;
(
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output var  logic              hreadyout,
  output var  logic [31:0]       hrdata,
  output var  logic              hresp,
  input  wire logic              loop_tick,     // loop output source tick
  input  wire logic              ext_tick,      // external reference tick
  input  wire logic              loop_locked,   // raw lock detector
  input  wire logic              stop_req,      // stop mode active
  output var  logic              bus_tick,      // divided bus tick
  output var  logic              int_ref_tick,  // internal reference tick
  output var  logic              osc_high_range,
  output var  logic              osc_high_gain,
  output var  logic              ext_ref_source_select,
  output var  logic              loop_enable,
  output var  logic              ext_ref_enable,
  output var  logic              ext_ref_clock_out,
  output var  logic              lock_status
);

  clkgen_state_t st;       // registered state
  clkgen_state_t next_st;  // next state
  clkgen_ctrl_t  ctrl;     // decoded fields of the live registers
  logic          src_tick; // tick of the selected system source
  logic          irc_tick; // internal reference tick from the model
  logic          div_tick; // bus tick from the divider

  // ==========================================================
  // helpers
  // ==========================================================
  // hit flag of a bus address, false for a miss outside the block
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    addr_hit = (a[ADDR_W-1:DEC_LSB] == '0);
  endfunction : addr_hit

  // byte read view of one register
  function automatic logic [7:0] reg_view(input clkgen_state_t s,
                                          input logic [1:0]    idx);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      IDX_CTRL_ONE:   v = s.ctrl_one;
      IDX_CTRL_TWO:   v = s.ctrl_two;
      IDX_PERIOD_ADJ: v = s.period_adj;
      default:
      begin
        v[LOCK_BIT] = s.lock;
        v[FINE_BIT] = s.fine_adj;
      end
    endcase
    reg_view = v;
  endfunction : reg_view

  // ==========================================================
  // field decode
  // ==========================================================
  always_comb
  begin
    ctrl.src_sel      = st.ctrl_one[SRC_SEL_MSB:SRC_SEL_LSB];
    ctrl.int_ref_sel  = st.ctrl_one[INT_REF_SEL];
    ctrl.bus_div      = st.ctrl_two[BUS_CLOCK_DIVIDER_MSB:BUS_CLOCK_DIVIDER_LSB];
    ctrl.high_range   = st.ctrl_two[RANGE_BIT];
    ctrl.high_gain    = st.ctrl_two[HIGH_GAIN_BIT];
    ctrl.lp_bypass    = st.ctrl_two[LP_BYPASS_BIT];
    ctrl.ref_src_osc  = st.ctrl_two[REF_SRC_BIT];
    ctrl.out_en       = st.ctrl_two[OUT_EN_BIT];
    ctrl.keep_in_stop = st.ctrl_two[KEEP_STOP_BIT];
  end

  // ==========================================================
  // system source selection
  // ==========================================================
  // the reserved code falls back to the loop output
  always_comb
  begin
    case (ctrl.src_sel)
      SRC_INT_REF: src_tick = irc_tick;
      SRC_EXT_REF: src_tick = ext_tick;
      default:     src_tick = loop_tick;
    endcase
  end

  // ==========================================================
  // sub-blocks
  // ==========================================================
  clkgen_bus_div u_bus_div (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .src_tick (src_tick),
    .div_code (ctrl.bus_div),
    .bus_tick (div_tick)
  );

  clkgen_irc u_irc (
    .hclk    (hclk),
    .hresetn (hresetn),
    .run     (st.int_ref_run),
    .adjust  ({st.period_adj, st.fine_adj}),
    .tick    (irc_tick)
  );

  // ==========================================================
  // next state: bus slave, registers and clock controls
  // ==========================================================
  always_comb
  begin
    logic       take;        // address phase accepted this cycle
    logic [1:0] a_idx;       // register index of the address phase
    logic [7:0] wbyte;       // written byte
    logic [7:0] rbyte;       // byte returned to a read
    logic       adj_changed; // period adjust write changed the value
    logic       bypass;      // loop output not feeding the system
    logic       int_loop;    // internal reference loop mode
    logic       ext_mode;    // mode relying on the external reference
    logic       in_stop;     // stop mode in force
    take        = 1'b0;
    a_idx       = 2'h0;
    wbyte       = 8'h00;
    rbyte       = 8'h00;
    adj_changed = 1'b0;
    bypass      = 1'b0;
    int_loop    = 1'b0;
    ext_mode    = 1'b0;
    in_stop     = 1'b0;
    next_st     = st;

    // data phase of a pending write: value takes effect at once
    wbyte = hwdata[7:0];
    if (st.wr_pend)
    begin
      case (st.wr_idx)
        IDX_CTRL_ONE:   next_st.ctrl_one = wbyte;
        IDX_CTRL_TWO:   next_st.ctrl_two = wbyte;
        IDX_PERIOD_ADJ:
        begin
          next_st.period_adj = wbyte;
          adj_changed        = (wbyte != st.period_adj);
        end
        default:        next_st.fine_adj = wbyte[FINE_BIT];
      endcase
    end
    next_st.wr_pend = 1'b0;

    // address phase; zero wait states, so hsel, hready and a NONSEQ or SEQ htrans gate it
    take  = hsel && hready && (htrans == HTRANS_NONSEQ ||
                               htrans == HTRANS_SEQ);
    a_idx = haddr[IDX_MSB:IDX_LSB];
    if (take && hwrite && addr_hit(haddr))
    begin
      next_st.wr_pend = 1'b1;
      next_st.wr_idx  = a_idx;
    end
    if (take && !hwrite)
    begin
      // a read right behind a write sees the value being written
      if (!addr_hit(haddr))
        rbyte = 8'h00;
      else if (st.wr_pend && st.wr_idx == a_idx)
        rbyte = reg_view(next_st, a_idx);
      else
        rbyte = reg_view(st, a_idx);
      next_st.hrdata = {24'h000000, rbyte};
    end

    // mode decode from the live registers
    bypass   = (ctrl.src_sel == SRC_INT_REF) ||
               (ctrl.src_sel == SRC_EXT_REF);
    int_loop = ctrl.int_ref_sel &&
               (ctrl.src_sel != SRC_EXT_REF);   // engaged or bypassed
    ext_mode = !ctrl.int_ref_sel;
    in_stop  = stop_req;

    // remember the mode at stop entry for the keep-running decision
    next_st.stop_prev = in_stop;
    if (in_stop && !st.stop_prev)
      next_st.ext_before_stop = ext_mode;

    // loop power: off in bypass when low power chosen, off in stop
    next_st.loop_en = !(bypass && ctrl.lp_bypass) && !in_stop;

    // external reference runs outside stop, and in stop only if asked
    // and the reference was in use
    if (!in_stop)
      next_st.ext_ref_run = 1'b1;
    else
      next_st.ext_ref_run = ctrl.keep_in_stop &&
                            (ctrl.out_en || st.ext_before_stop);
    next_st.ext_ref_out = ext_tick && ctrl.out_en &&
                          next_st.ext_ref_run;

    // internal reference needed when selected as source or reference
    next_st.int_ref_run = !in_stop &&
                          (ctrl.int_ref_sel ||
                           ctrl.src_sel == SRC_INT_REF);

    // oscillator settings follow the register without a commit step
    next_st.high_range  = ctrl.high_range;
    next_st.high_gain   = ctrl.high_gain;
    next_st.ref_src_osc = ctrl.ref_src_osc;

    // lock: follows the detector, dropped by an adjust change in an
    // internal loop mode until the detector reports lock afresh
    next_st.locked_prev = loop_locked;
    if (!loop_locked || !next_st.loop_en)
      next_st.lock = 1'b0;
    else if (adj_changed && int_loop && st.lock)
      next_st.lock = 1'b0;
    else if (loop_locked && !st.locked_prev)
      next_st.lock = 1'b1;
  end

  // ==========================================================
  // state register
  // ==========================================================
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st            <= '0;
      st.ctrl_one   <= RST_CTRL_ONE;
      st.ctrl_two   <= RST_CTRL_TWO;
      st.period_adj <= RST_PERIOD_ADJ;   // software loads stored value
      st.fine_adj   <= RST_FINE;
      st.loop_en    <= 1'b1;
      st.ext_ref_run <= 1'b1;
      st.int_ref_run <= 1'b1;
    end
    else
      st <= next_st;
  end

  // ==========================================================
  // outputs, each straight from a flip-flop except the tied hreadyout and hresp
  // ==========================================================
  assign hreadyout             = 1'b1;   // never inserts wait states
  assign hresp                 = HRESP_OKAY;
  assign hrdata                = st.hrdata;
  assign bus_tick              = div_tick;
  assign int_ref_tick          = irc_tick;
  assign osc_high_range        = st.high_range;
  assign osc_high_gain         = st.high_gain;
  assign ext_ref_source_select = st.ref_src_osc;
  assign loop_enable           = st.loop_en;
  assign ext_ref_enable        = st.ext_ref_run;
  assign ext_ref_clock_out     = st.ext_ref_out;
  assign lock_status           = st.lock;

endmodule : clkgen_ctrl
`default_nettype wire

// ==== bench/clkgen_ctrl_properties.sv ====
/*
  Port checks for the clock generator control block.
  Assumes a single hclk domain and a bind from the bench top file.
*/
`timescale 1ns/1ps
`default_nettype none
module clkgen_ctrl_properties
  import clkgen_pkg::*;
(
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic              hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [31:0]       hwdata,
  input wire logic              hready,
  input wire logic              hreadyout,
  input wire logic [31:0]       hrdata,
  input wire logic              hresp,
  input wire logic              ext_tick,
  input wire logic              loop_locked,
  input wire logic              stop_req,
  input wire logic              osc_high_range,
  input wire logic              osc_high_gain,
  input wire logic              ext_ref_source_select,
  input wire logic              loop_enable,
  input wire logic              ext_ref_enable,
  input wire logic              ext_ref_clock_out,
  input wire logic              lock_status
);
  // ==========================================================
  // helpers
  // ==========================================================
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd_take; // read address phase taken at this edge
  assign rd_take = hsel & hready & htrans[1] & ~hwrite;
  // address phase of a write to control two
  sequence s_wr_two;
    hsel && hready && htrans[1] && hwrite && haddr == 12'h004;
  endsequence
  // ==========================================================
  // assertions
  // ==========================================================
  a_resp_okay: assert property (hresp == HRESP_OKAY)
    else $error("hresp not OKAY");
  a_zero_wait: assert property (hreadyout == 1'b1)
    else $error("hreadyout dropped");
  a_upper_zero: assert property (hrdata[31:8] == 24'h000000)
    else $error("read data above byte 0 not zero");
  a_read_hold: assert property (!$past(rd_take) |-> $stable(hrdata))
    else $error("hrdata moved without a read");
  a_wr_two_effect: assert property (s_wr_two ##1 1'b1 |-> ##2
    {osc_high_range, osc_high_gain, ext_ref_source_select} ==
    {$past(hwdata[5], 2), $past(hwdata[4], 2), $past(hwdata[2], 2)})
    else $error("control two fields not applied");
  a_stop_loop_off: assert property ($past(stop_req) |-> !loop_enable)
    else $error("loop still enabled in stop");
  a_run_out_stop: assert property (!$past(stop_req) |-> ext_ref_enable)
    else $error("external reference off outside stop");
  a_out_cause: assert property (ext_ref_clock_out |-> $past(ext_tick))
    else $error("reference output pulse without a source tick");
  a_lock_det: assert property (lock_status |-> $past(loop_locked))
    else $error("lock shown with detector low");
endmodule : clkgen_ctrl_properties
`default_nettype wire

// ==== bench/clock_gen_ctrl2_and_trim_bench.sv ====
/*
  Self-checking bench for clkgen_ctrl: AHB-Lite register access, bus
  divider, period adjust, stop gating and lock.
  Assumes hreadyout is fed back as hready (single slave).
*/
`timescale 1ns/1ps
`default_nettype none
module clock_gen_ctrl2_and_trim_bench;
  import clkgen_pkg::*;
  logic        hclk, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata, rdv;
  logic        loop_tick = 1'b0, ext_tick = 1'b0;
  logic        loop_locked = 1'b0, stop_req = 1'b0;
  logic        hreadyout, hresp, bus_tick, int_ref_tick, osc_high_range;
  logic        osc_high_gain, ext_ref_source_select, loop_enable;
  logic        ext_ref_enable, ext_ref_clock_out, lock_status;
  int          fail_count = 0, tests_run = 0, bus_cnt, out_cnt;

  clkgen_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .loop_tick(loop_tick),
    .ext_tick(ext_tick), .loop_locked(loop_locked), .stop_req(stop_req),
    .bus_tick(bus_tick), .int_ref_tick(int_ref_tick),
    .osc_high_range(osc_high_range), .osc_high_gain(osc_high_gain),
    .ext_ref_source_select(ext_ref_source_select),
    .loop_enable(loop_enable), .ext_ref_enable(ext_ref_enable),
    .ext_ref_clock_out(ext_ref_clock_out), .lock_status(lock_status));

  // ==========================================================
  // clock and pulse counters
  // ==========================================================
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // counters are cleared only while the outputs are quiet
  always @(posedge hclk)
  begin
    if (bus_tick === 1'b1) bus_cnt++;
    if (ext_ref_clock_out === 1'b1) out_cnt++;
  end

  // ==========================================================
  // shared tasks
  // ==========================================================
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc
  // one single transfer; waits on hready rather than assuming zero waits
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr  <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask : xfer
  // loop tick every cycle, external tick every other cycle
  task automatic pump(input int n);
    for (int i = 0; i < n; i++)
    begin
      loop_tick <= 1'b1;
      ext_tick  <= i[0];
      @(posedge hclk);
    end
    loop_tick <= 1'b0;
    ext_tick  <= 1'b0;
    cyc(4);
  endtask : pump
  task automatic irc_gap(output int g);
    g = 0;
    do @(posedge hclk); while (int_ref_tick !== 1'b1);
    do
    begin
      @(posedge hclk);
      g++;
    end
    while (int_ref_tick !== 1'b1);
  endtask : irc_gap

  // ==========================================================
  // scenarios
  // ==========================================================
  task automatic t_regs;
    xfer(1'b0, 12'h004, 32'h0);
    chk("control two reset", 32'h40, rdv);
    xfer(1'b0, 12'h008, 32'h0);
    chk("adjust reset", {24'h0, RST_PERIOD_ADJ}, rdv);
    xfer(1'b1, 12'h004, 32'hF5);
    xfer(1'b0, 12'h004, 32'h0);
    chk("control two readback", 32'hF5, rdv);
    cyc(2);
    chk("osc fields", 32'h7, {osc_high_range, osc_high_gain, ext_ref_source_select});
    xfer(1'b1, 12'h004, 32'h0A);
    xfer(1'b1, 12'h010, 32'hFF);
    xfer(1'b0, 12'h010, 32'h0);
    chk("unmapped read", 32'h0, rdv);
    xfer(1'b0, 12'h004, 32'h0);
    chk("control two kept", 32'h0A, rdv);
    cyc(2);
    chk("osc fields low", 32'h0, {osc_high_range, osc_high_gain, ext_ref_source_select});
  endtask : t_regs
  task automatic t_divider;
    logic [1:0] srcs [3] = '{2'h0, 2'h2, 2'h3};
    int         e;
    foreach (srcs[s])
      for (int d = 0; d < 4; d++)
      begin
        xfer(1'b1, 12'h000, {24'h0, srcs[s], 6'h04});
        xfer(1'b1, 12'h004, 32'(d << 6));
        cyc(4);
        bus_cnt = 0;
        pump(32);
        e = (srcs[s] == 2'h2 ? 16 : 32) >> d;
        chk("bus ticks", e, (bus_cnt > e + 1 || bus_cnt < e - 1) ? bus_cnt : e);
      end
  endtask : t_divider
  task automatic t_period;
    logic [8:0] v [5] = '{9'h000, 9'h002, 9'h004, 9'h100, 9'h001};
    int         g;
    xfer(1'b1, 12'h000, 32'h44);
    foreach (v[i])
    begin
      xfer(1'b1, 12'h008, {24'h0, v[i][8:1]});
      xfer(1'b1, 12'h00C, {31'h0, v[i][0]});
      irc_gap(g);
      irc_gap(g);
      chk("reference period", 17 + v[i], g);
    end
  endtask : t_period
  task automatic t_modes;
    logic [18:0] tab [9] = '{{8'h80, 8'h08, 3'b001}, {8'h80, 8'h00, 3'b011},
      {8'h40, 8'h08, 3'b001}, {8'h00, 8'h08, 3'b011}, {8'h04, 8'h03, 3'b101},
      {8'h04, 8'h01, 3'b100}, {8'h04, 8'h02, 3'b100}, {8'h00, 8'h01, 3'b101},
      {8'h00, 8'h00, 3'b100}};
    foreach (tab[i])
    begin
      xfer(1'b1, 12'h000, {24'h0, tab[i][18:11]});
      xfer(1'b1, 12'h004, {24'h0, tab[i][10:3]});
      stop_req <= tab[i][2];
      cyc(3);
      chk("loop enable", tab[i][1], loop_enable);
      chk("ext ref enable", tab[i][0], ext_ref_enable);
      stop_req <= 1'b0;
      cyc(3);
    end
  endtask : t_modes
  task automatic t_ext_out;
    xfer(1'b1, 12'h000, 32'h04);
    for (int k = 0; k < 2; k++)
    begin
      xfer(1'b1, 12'h004, k ? 32'h00 : 32'h02);
      cyc(4);
      out_cnt = 0;
      pump(16);
      chk("ext ref pulses", k ? 0 : 8, out_cnt);
    end
  endtask : t_ext_out
  task automatic t_lock;
    xfer(1'b1, 12'h004, 32'h40);
    loop_locked <= 1'b1;
    cyc(4);
    chk("lock set", 32'h1, lock_status);
    xfer(1'b0, 12'h00C, 32'h0);
    chk("status lock bit", 32'h40, rdv & 32'h40);
    xfer(1'b1, 12'h008, 32'h33);
    cyc(3);
    chk("lock after adjust", 32'h0, lock_status);
    loop_locked <= 1'b0;
  endtask : t_lock

  // ==========================================================
  // run control
  // ==========================================================
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out
  // whole run is a few thousand cycles; this bound only catches hangs
  initial
  begin
    repeat (20000) @(posedge hclk);
    fail_count++;
    close_out();
  end
  initial
  begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_divider();
    t_period();
    t_modes();
    t_ext_out();
    t_lock();
    close_out();
  end
endmodule : clock_gen_ctrl2_and_trim_bench
bind clkgen_ctrl clkgen_ctrl_properties u_props (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
  .ext_tick(ext_tick), .loop_locked(loop_locked), .stop_req(stop_req),
  .osc_high_range(osc_high_range), .osc_high_gain(osc_high_gain),
  .ext_ref_source_select(ext_ref_source_select),
  .loop_enable(loop_enable), .ext_ref_enable(ext_ref_enable),
  .ext_ref_clock_out(ext_ref_clock_out), .lock_status(lock_status));
`default_nettype wire
